/* File: hw/acio_regs.svh */
// Register offsets, field positions, reset values and timing counts of the aux connector block
`ifndef ACIO_REGS_SVH
`define ACIO_REGS_SVH

// Byte offsets on the register bus
`define ACIO_OFS_CFG0        5'h00
`define ACIO_OFS_CFG1        5'h04
`define ACIO_OFS_CFG2        5'h08
`define ACIO_OFS_GLOBAL      5'h0c
`define ACIO_OFS_WIN         5'h10
`define ACIO_OFS_TMO         5'h14
`define ACIO_OFS_STAT        5'h18

// Per-connector configuration fields
`define ACIO_CFG_OUT_EN      0
`define ACIO_CFG_COINC       1
`define ACIO_CFG_POL_HIGH    2
`define ACIO_CFG_START       3
`define ACIO_CFG_SEL_LSB     4
`define ACIO_CFG_SEL_MSB     7
`define ACIO_CFG_WIDTH       8

// Global configuration fields
`define ACIO_GLB_RTC_LSB     0
`define ACIO_GLB_RTC_MSB     1
`define ACIO_GLB_AT_END      2
`define ACIO_GLB_WIDTH       3

// Reset values
`define ACIO_CFG_RST         8'h04
`define ACIO_GLB_RST         3'h3
`define ACIO_WIN_RST         16'h0050
`define ACIO_TMO_RST         16'h0050

// Timing
`define ACIO_CLK_MHZ         25
`define ACIO_CLK_NS          (1000 / `ACIO_CLK_MHZ)
`define ACIO_STEP_NS         50
`define ACIO_MIN_STEPS       16'h0003
`define ACIO_MAX_STEPS       16'hfff0
`define ACIO_CLEANUP_NS      200
`define ACIO_CLEANUP_CYC     ((`ACIO_CLEANUP_NS + `ACIO_CLK_NS - 1) / `ACIO_CLK_NS)

`endif

/* File: hw/acio_pkg.sv */
// Types shared by the aux connector block
package acio_pkg;

  typedef enum logic [3:0] {
    SRC_COINC_TIME   = 4'h0,
    SRC_COINC_RUNS   = 4'h1,
    SRC_COINC_FINISH = 4'h2,
    SRC_COINC_ACTIVE = 4'h3,
    SRC_SWEEP_ON     = 4'h4,
    SRC_SWEEP_START  = 4'h5,
    SRC_DEAD_1       = 4'h6,
    SRC_DEAD_8       = 4'hd,
    SRC_LOW          = 4'he,
    SRC_HIGH         = 4'hf
  } acio_src_t;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_WINDOW  = 4'b0010,
    ST_TIMEOUT = 4'b0100,
    ST_CLEANUP = 4'b1000
  } acio_state_t;

endpackage : acio_pkg

/* File: hw/acio_conn_if.sv */
// Signals between the block core and one connector slice
`timescale 1ns/10ps
interface acio_conn_if;
  logic        out_en;
  logic        pol_high;
  logic [3:0]  out_sel;
  logic [15:0] src;
  logic        active_edge;
  logic        level;

  modport core (output out_en, output pol_high, output out_sel, output src,
                input active_edge, input level);
  modport conn (input out_en, input pol_high, input out_sel, input src,
                output active_edge, output level);
endinterface : acio_conn_if

/* File: hw/acio_conn.sv */
// One connector slice: input synchroniser, edge detect, registered output mux
`timescale 1ns/10ps
module acio_conn (
  input  wire logic    clk,
  input  wire logic    rst,
  input  wire logic    pin_in,
  output logic         pin_out,
  output logic         pin_oe_n,
  acio_conn_if.conn    port
);

  logic sync_a;
  logic sync_b;
  logic prev;
  wire  rise_seen = sync_b & ~prev;
  wire  fall_seen = ~sync_b & prev;
  wire  sel_bit   = port.src[port.out_sel];

  always_ff @(posedge clk) begin
    if (rst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev   <= 1'b0;
    end else begin
      sync_a <= pin_in;
      sync_b <= sync_a;
      prev   <= sync_b;
    end
  end

  // Driven connector never reports input events
  assign port.level       = sync_b;
  assign port.active_edge = ~port.out_en & (port.pol_high ? rise_seen : fall_seen);

  // Registered mux keeps source changes glitch free on the pin
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_out  <= 1'b0;
      pin_oe_n <= 1'b1;
    end else begin
      pin_out  <= sel_bit;
      pin_oe_n <= ~port.out_en;
    end
  end

endmodule : acio_conn

/* File: hw/acio_top.sv */
// Aux connector block: register slave, coincidence sequencer, connector routing
`timescale 1ns/10ps
`include "acio_regs.svh"
module acio_top #(
  parameter int NCONN = 3
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [2:0]  aux_pin_in,
  output logic [2:0]       aux_pin_out,
  output logic [2:0]       aux_pin_oe_n,
  input  wire logic        ext_start,
  input  wire logic        sweep_on,
  input  wire logic        sweep_start,
  input  wire logic [7:0]  adc_busy,
  output logic [1:0]       coinc_entry,
  output logic             coinc_window_open,
  output logic             coinc_drop,
  output logic             rtc_reset
);

  localparam logic [21:0] CLK_NS  = 22'(`ACIO_CLK_NS);
  localparam logic [21:0] STEP_NS = 22'(`ACIO_STEP_NS);
  localparam logic [3:0]  CLN_CYC = 4'(`ACIO_CLEANUP_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // Register bus slave

  logic [`ACIO_CFG_WIDTH-1:0] cfg [NCONN];
  logic [`ACIO_GLB_WIDTH-1:0] glb;
  logic [15:0]                win_steps;
  logic [15:0]                tmo_steps;
  logic                       drop_pending;
  acio_pkg::acio_state_t      state;
  acio_pkg::acio_state_t      next_state;

  wire        bus_req   = avs_read | avs_write;
  wire        bus_done  = bus_req & ~avs_waitrequest;
  wire        wr_take   = avs_write & bus_done;
  wire        hit_cfg0  = avs_address == `ACIO_OFS_CFG0;
  wire        hit_cfg1  = avs_address == `ACIO_OFS_CFG1;
  wire        hit_cfg2  = avs_address == `ACIO_OFS_CFG2;
  wire        hit_glb   = avs_address == `ACIO_OFS_GLOBAL;
  wire        hit_win   = avs_address == `ACIO_OFS_WIN;
  wire        hit_tmo   = avs_address == `ACIO_OFS_TMO;
  wire        hit_stat  = avs_address == `ACIO_OFS_STAT;
  wire [2:0]  pin_level;
  wire [31:0] stat_word = {24'h000000, drop_pending, state, pin_level};
  wire [31:0] rd_mux    = hit_cfg0 ? {24'h000000, cfg[0]} :
                          hit_cfg1 ? {24'h000000, cfg[1]} :
                          hit_cfg2 ? {24'h000000, cfg[2]} :
                          hit_glb  ? {29'h00000000, glb} :
                          hit_win  ? {16'h0000, win_steps} :
                          hit_tmo  ? {16'h0000, tmo_steps} :
                          hit_stat ? stat_word : 32'h00000000;

  // One wait cycle; writes land at the edge that completes the transfer
  always_ff @(posedge clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
      if (avs_read & avs_waitrequest) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg[0]    <= `ACIO_CFG_RST;
      cfg[1]    <= `ACIO_CFG_RST;
      cfg[2]    <= `ACIO_CFG_RST;
      glb       <= `ACIO_GLB_RST;
      win_steps <= `ACIO_WIN_RST;
      tmo_steps <= `ACIO_TMO_RST;
    end else if (wr_take) begin
      if (hit_cfg0) cfg[0] <= avs_writedata[`ACIO_CFG_WIDTH-1:0];
      if (hit_cfg1) cfg[1] <= avs_writedata[`ACIO_CFG_WIDTH-1:0];
      if (hit_cfg2) cfg[2] <= avs_writedata[`ACIO_CFG_WIDTH-1:0];
      if (hit_glb)  glb    <= avs_writedata[`ACIO_GLB_WIDTH-1:0];
      if (hit_win)  win_steps <= avs_writedata[15:0];
      if (hit_tmo)  tmo_steps <= avs_writedata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Connector slices

  wire [15:0] src_vec;
  wire [2:0]  edge_seen;
  wire        st_window  = state == acio_pkg::ST_WINDOW;
  wire        st_timeout = state == acio_pkg::ST_TIMEOUT;
  wire        st_cleanup = state == acio_pkg::ST_CLEANUP;
  wire        st_busy    = state != acio_pkg::ST_IDLE;

  assign src_vec[acio_pkg::SRC_COINC_TIME]   = st_window;
  assign src_vec[acio_pkg::SRC_COINC_RUNS]   = st_window | st_timeout;
  assign src_vec[acio_pkg::SRC_COINC_FINISH] = st_cleanup;
  assign src_vec[acio_pkg::SRC_COINC_ACTIVE] = st_busy;
  assign src_vec[acio_pkg::SRC_SWEEP_ON]     = sweep_on;
  assign src_vec[acio_pkg::SRC_SWEEP_START]  = sweep_start;
  assign src_vec[acio_pkg::SRC_DEAD_8:acio_pkg::SRC_DEAD_1] = adc_busy;
  assign src_vec[acio_pkg::SRC_LOW]          = 1'b0;
  assign src_vec[acio_pkg::SRC_HIGH]         = 1'b1;

  genvar gi;
  generate
    for (gi = 0; gi < NCONN; gi++) begin : g_conn
      acio_conn_if cif ();
      assign cif.out_en    = cfg[gi][`ACIO_CFG_OUT_EN];
      assign cif.pol_high  = cfg[gi][`ACIO_CFG_POL_HIGH];
      assign cif.out_sel   = cfg[gi][`ACIO_CFG_SEL_MSB:`ACIO_CFG_SEL_LSB];
      assign cif.src       = src_vec;
      assign edge_seen[gi] = cif.active_edge;
      assign pin_level[gi] = cif.level;
      acio_conn u_conn (
        .clk      (clk),
        .rst      (rst),
        .pin_in   (aux_pin_in[gi]),
        .pin_out  (aux_pin_out[gi]),
        .pin_oe_n (aux_pin_oe_n[gi]),
        .port     (cif.conn)
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Coincidence participation

  wire coinc0     = cfg[0][`ACIO_CFG_COINC];
  wire coinc1     = cfg[1][`ACIO_CFG_COINC];
  // Second aux takes the shared entry if both ask for it
  wire rej_coinc  = cfg[2][`ACIO_CFG_COINC] & ~coinc1;
  wire entry0_hit = edge_seen[0] & coinc0;
  wire entry1_hit = coinc1 ? edge_seen[1] : 1'b0;
  wire start_hit  = ext_start
                  | (entry0_hit & cfg[0][`ACIO_CFG_START])
                  | (entry1_hit & cfg[1][`ACIO_CFG_START]);
  wire rej_hit    = edge_seen[2] & rej_coinc & st_busy;
  wire at_end     = glb[`ACIO_GLB_AT_END];
  wire [1:0] rtc_sel = glb[`ACIO_GLB_RTC_MSB:`ACIO_GLB_RTC_LSB];
  // Select value 3 leaves the clock reset unused
  wire rtc_hit    = (rtc_sel != 2'h3) & edge_seen[rtc_sel];

  ////////////////////////////////////////////////////////////////////////////
  // Window and timeout sequencer

  // Steps of 50 ns do not divide the 40 ns clock, so time runs in ns
  wire [15:0] win_clamp = win_steps < `ACIO_MIN_STEPS ? `ACIO_MIN_STEPS :
                          win_steps > `ACIO_MAX_STEPS ? `ACIO_MAX_STEPS : win_steps;
  wire [15:0] tmo_clamp = tmo_steps < `ACIO_MIN_STEPS ? `ACIO_MIN_STEPS :
                          tmo_steps > `ACIO_MAX_STEPS ? `ACIO_MAX_STEPS : tmo_steps;
  wire [21:0] win_ns    = 22'(22'(win_clamp) * STEP_NS);
  wire [21:0] tmo_ns    = 22'(22'(tmo_clamp) * STEP_NS);

  logic [21:0] elapsed;
  logic [3:0]  cln_cnt;
  wire  [21:0] next_elapsed = 22'(elapsed + CLK_NS);
  wire         win_done     = st_window & (next_elapsed >= win_ns);
  wire         tmo_done     = st_timeout & (next_elapsed >= tmo_ns);
  wire         cln_done     = st_cleanup & (cln_cnt == CLN_CYC - 4'h1);

  always_comb begin
    next_state = state;
    case (state)
      acio_pkg::ST_IDLE:    if (start_hit) next_state = acio_pkg::ST_WINDOW;
      acio_pkg::ST_WINDOW:  if (win_done)  next_state = acio_pkg::ST_TIMEOUT;
      acio_pkg::ST_TIMEOUT: if (tmo_done)  next_state = acio_pkg::ST_CLEANUP;
      acio_pkg::ST_CLEANUP: if (cln_done)  next_state = acio_pkg::ST_IDLE;
      default:              next_state = acio_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state   <= acio_pkg::ST_IDLE;
      elapsed <= 22'h000000;
      cln_cnt <= 4'h0;
    end else begin
      state   <= next_state;
      elapsed <= (next_state != state) ? 22'h000000 : next_elapsed;
      cln_cnt <= st_cleanup ? 4'(cln_cnt + 4'h1) : 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event outputs

  // A reject arriving as the window closes is still honoured
  wire drop_now  = at_end ? (win_done & (drop_pending | rej_hit)) : rej_hit;
  wire next_pend = at_end & st_window & ~win_done & (drop_pending | rej_hit);

  always_ff @(posedge clk) begin
    if (rst) begin
      coinc_entry       <= 2'h0;
      coinc_window_open <= 1'b0;
      coinc_drop        <= 1'b0;
      drop_pending      <= 1'b0;
      rtc_reset         <= 1'b0;
    end else begin
      coinc_entry       <= {entry1_hit, entry0_hit};
      coinc_window_open <= next_state == acio_pkg::ST_WINDOW;
      coinc_drop        <= drop_now;
      drop_pending      <= next_pend;
      rtc_reset         <= rtc_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_bus_answer: assert property (@(posedge clk) disable iff (rst)
    bus_req && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered in one cycle");

  a_win_min: assert property (@(posedge clk) disable iff (rst)
    $rose(st_window) |-> st_window[*4])
    else $error("window shorter than minimum");

  a_runs_cover: assert property (@(posedge clk) disable iff (rst)
    st_window ##1 !st_window |-> st_timeout)
    else $error("timeout does not follow window");

  a_clean_len: assert property (@(posedge clk) disable iff (rst)
    $rose(st_cleanup) |-> st_cleanup[*5] ##1 state == acio_pkg::ST_IDLE)
    else $error("cleanup length wrong");

  a_entry_cause: assert property (@(posedge clk) disable iff (rst)
    coinc_entry[0] |-> $past(edge_seen[0]) && $past(coinc0))
    else $error("entry without coincidence mode");

  a_entry_share: assert property (@(posedge clk) disable iff (rst)
    edge_seen[2] && !edge_seen[1] |=> !coinc_entry[1])
    else $error("reject leaked into shared entry");

  a_drop_instant: assert property (@(posedge clk) disable iff (rst)
    rej_hit && !at_end |=> coinc_drop)
    else $error("instant reject not dropped");

  a_drop_end: assert property (@(posedge clk) disable iff (rst)
    coinc_drop && $past(at_end) |-> $past(win_done))
    else $error("end-of-window drop off the window end");

  a_rtc_reset: assert property (@(posedge clk) disable iff (rst)
    edge_seen[0] && rtc_sel == 2'h0 |=> rtc_reset)
    else $error("clock reset not issued");

  a_oe_follow: assert property (@(posedge clk) disable iff (rst)
    cfg[0][`ACIO_CFG_OUT_EN] |=> !aux_pin_oe_n[0])
    else $error("output enable not applied");

  a_src_high: assert property (@(posedge clk) disable iff (rst)
    (cfg[0][`ACIO_CFG_OUT_EN] && cfg[0][7:4] == 4'hf) ##1
    (cfg[0][`ACIO_CFG_OUT_EN] && cfg[0][7:4] == 4'hf) |-> aux_pin_out[0])
    else $error("constant high source not driven");

  a_start_open: assert property (@(posedge clk) disable iff (rst)
    start_hit && state == acio_pkg::ST_IDLE |=> st_window)
    else $error("start did not open window");

  a_pin_source: assert property (@(posedge clk) disable iff (rst)
    cfg[2][`ACIO_CFG_OUT_EN] |=> aux_pin_out[2] == $past(src_vec[cfg[2][`ACIO_CFG_SEL_MSB:`ACIO_CFG_SEL_LSB]]))
    else $error("pin not driven from registered source");

  a_drop_busy: assert property (@(posedge clk) disable iff (rst)
    coinc_drop |-> $past(st_busy))
    else $error("drop outside coincidence processing");

  a_input_quiet: assert property (@(posedge clk) disable iff (rst)
    cfg[1][`ACIO_CFG_OUT_EN] |-> !edge_seen[1])
    else $error("driven connector reported an edge");

  c_full_cycle: cover property (@(posedge clk) disable iff (rst)
    st_cleanup ##1 state == acio_pkg::ST_IDLE);

  c_drop_end: cover property (@(posedge clk) disable iff (rst)
    coinc_drop && at_end);

  c_rtc: cover property (@(posedge clk) disable iff (rst)
    rtc_reset && rtc_sel == 2'h2);

endmodule : acio_top

/* File: tb/acio_ttl_model.sv */
// Behavioural model of the external TTL equipment on the three connectors
`timescale 1ns/10ps
module acio_ttl_model (
  input  wire logic [2:0] pin_out,
  input  wire logic [2:0] pin_oe_n,
  input  wire logic [2:0] ext_lvl,
  output logic [2:0]      pin_in
);
  // Equipment backs off wherever the device drives, so the line never fights
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pin_in[i] = pin_oe_n[i] ? ext_lvl[i] : pin_out[i];
    end
  end
endmodule : acio_ttl_model

/* File: tb/acio_top_tb.sv */
// Self-checking bench of the aux connector block
`timescale 1ns/10ps
`include "acio_regs.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module acio_top_tb;
  logic        clk         = 1'b0;
  logic        rst         = 1'b1;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read    = 1'b0;
  logic        avs_write   = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [2:0]  pin_in;
  logic [2:0]  pin_out;
  logic [2:0]  pin_oe_n;
  logic [2:0]  ext_lvl     = 3'h0;
  logic        ext_start   = 1'b0;
  logic        sweep_on    = 1'b0;
  logic        sweep_start = 1'b0;
  logic [7:0]  adc_busy    = 8'h00;
  logic [1:0]  coinc_entry;
  logic        win_open;
  logic        drop;
  logic        rtc_reset;
  wire  [7:0]  probe       = {rtc_reset, drop, win_open, coinc_entry, pin_in};
  int          fail_count  = 0;
  int          n_compared  = 0;
  int          cyc         = 0;
  int          hi [8];
  logic        at_drop;
  logic [31:0] rd;
  localparam logic [31:0] RV [8] = '{32'h04, 32'h04, 32'h04, 32'h3, 32'h50, 32'h50, 32'h08, 32'h0};

  acio_top #(.NCONN(3)) i_acio_top (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .aux_pin_in(pin_in), .aux_pin_out(pin_out), .aux_pin_oe_n(pin_oe_n), .ext_start(ext_start),
    .sweep_on(sweep_on), .sweep_start(sweep_start), .adc_busy(adc_busy), .coinc_entry(coinc_entry),
    .coinc_window_open(win_open), .coinc_drop(drop), .rtc_reset(rtc_reset));

  acio_ttl_model i_acio_ttl_model (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_lvl(ext_lvl), .pin_in(pin_in));

  ////////////////////////////////////////////////////////////
  initial begin
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // Avalon access; waitrequest sampled at the rising edge, data taken at that edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) `CHK("waitrequest", 1'b0, avs_waitrequest)
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic set_pin(input int i, input logic v);
    @(posedge clk);
    ext_lvl[i] <= v;
  endtask : set_pin

  task automatic watch(input int n);
    for (int b = 0; b < 8; b++) hi[b] = 0;
    at_drop = 1'b0;
    repeat (n) begin
      @(negedge clk);
      for (int b = 0; b < 8; b++) if (probe[b] === 1'b1) hi[b]++;
      if (probe[6] === 1'b1) at_drop = probe[5];
    end
  endtask : watch

  function automatic logic exp_src(input int s, input int p);
    logic [7:0] b;
    b = p ? 8'h5a : 8'ha5;
    case (s)
      4:       return p == 0;
      5:       return p != 0;
      14:      return 1'b0;
      15:      return 1'b1;
      default: return b[s-6];
    endcase
  endfunction : exp_src

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK("oe_n at reset", 3'h7, pin_oe_n)
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, 5'(4 * i), 32'h0);
      `CHK("reset value", RV[i], rd)
    end
    wr(`ACIO_OFS_CFG0, 32'h1f5);
    bus(1'b0, `ACIO_OFS_CFG0, 32'h0);
    `CHK("cfg readback", 32'hf5, rd)
    wr(`ACIO_OFS_GLOBAL, 32'hff);
    bus(1'b0, `ACIO_OFS_GLOBAL, 32'h0);
    `CHK("global readback", 32'h7, rd)
    wr(5'h1c, 32'hffffffff);
    bus(1'b0, 5'h1c, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    wr(`ACIO_OFS_GLOBAL, 32'h3);
    $display("end of test registers");
    // Output source table, both input patterns
    for (int p = 0; p < 2; p++) begin
      @(posedge clk);
      sweep_on    <= (p == 0);
      sweep_start <= (p != 0);
      adc_busy    <= p ? 8'h5a : 8'ha5;
      for (int s = 4; s < 16; s++) begin
        wr(`ACIO_OFS_CFG0, 32'(s << 4) | 32'h1);
        watch(3);
        `CHK("source level", exp_src(s, p), pin_in[0])
      end
    end
    `CHK("drive enables", 3'h6, pin_oe_n)
    $display("end of test sources");
    // Window sequence with shortest counts
    wr(`ACIO_OFS_WIN, 32'h3);
    wr(`ACIO_OFS_TMO, 32'h3);
    wr(`ACIO_OFS_CFG1, 32'h11);
    wr(`ACIO_OFS_CFG2, 32'h01);
    wr(`ACIO_OFS_CFG0, 32'h0e);
    watch(4);
    set_pin(0, 1'b1);
    watch(30);
    `CHK("entry one", 1, hi[3])
    `CHK("window cycles", 4, hi[5])
    `CHK("window source", 4, hi[2])
    `CHK("window plus timeout", 8, hi[1])
    set_pin(0, 1'b0);
    watch(6);
    wr(`ACIO_OFS_CFG1, 32'h21);
    wr(`ACIO_OFS_CFG2, 32'h31);
    wr(`ACIO_OFS_CFG0, 32'h0a);
    set_pin(0, 1'b1);
    watch(10);
    `CHK("rise ignored", 0, hi[3])
    set_pin(0, 1'b0);
    watch(30);
    `CHK("fall accepted", 1, hi[3])
    `CHK("cleanup source", 5, hi[1])
    `CHK("processing source", 13, hi[2])
    wr(`ACIO_OFS_CFG0, 32'h0c);
    set_pin(0, 1'b1);
    watch(20);
    `CHK("no coinc entry", 0, hi[3])
    `CHK("no coinc window", 0, hi[5])
    set_pin(0, 1'b0);
    $display("end of test window");
    // Shared entry: second aux wins over reject
    wr(`ACIO_OFS_CFG0, 32'h04);
    wr(`ACIO_OFS_CFG1, 32'h06);
    wr(`ACIO_OFS_CFG2, 32'h06);
    watch(6);
    set_pin(2, 1'b1);
    watch(20);
    `CHK("reject no entry", 0, hi[4])
    set_pin(1, 1'b1);
    watch(20);
    `CHK("shared entry", 1, hi[4])
    `CHK("start disabled", 0, hi[5])
    set_pin(1, 1'b0);
    set_pin(2, 1'b0);
    watch(6);
    $display("end of test shared");
    // Reject, instant then at window end
    wr(`ACIO_OFS_WIN, 32'h14);
    wr(`ACIO_OFS_CFG1, 32'h04);
    for (int g = 0; g < 2; g++) begin
      wr(`ACIO_OFS_GLOBAL, g ? 32'h7 : 32'h3);
      @(posedge clk);
      ext_start <= 1'b1;
      @(posedge clk);
      ext_start <= 1'b0;
      set_pin(2, 1'b1);
      watch(60);
      `CHK("drop count", 1, hi[6])
      `CHK("drop inside window", g ? 1'b0 : 1'b1, at_drop)
      set_pin(2, 1'b0);
      watch(6);
    end
    $display("end of test reject");
    // Clock reset source, selected pin fires, neighbour does not
    for (int i = 0; i < 3; i++) begin
      wr(`ACIO_OFS_GLOBAL, 32'(i));
      set_pin(i, 1'b1);
      watch(10);
      `CHK("rtc selected", 1, hi[7])
      set_pin((i + 1) % 3, 1'b1);
      watch(10);
      `CHK("rtc other", 0, hi[7])
      set_pin(i, 1'b0);
      set_pin((i + 1) % 3, 1'b0);
      watch(6);
    end
    $display("end of test rtc");
    give_verdict();
  end
endmodule : acio_top_tb
